/* hdl/scd_regs.svh */
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH
// Admin opcodes for the two security commands.
`define SCD_OPC_SEC_SEND      8'h81
`define SCD_OPC_SEC_RECV      8'h82
// Storage command-set opcodes.
`define SCD_OPC_FLUSH         8'h00
`define SCD_OPC_WRITE         8'h01
`define SCD_OPC_READ          8'h02
`define SCD_OPC_WRITE_UNCORR  8'h04
`define SCD_OPC_COMPARE       8'h05
`define SCD_OPC_WRITE_ZEROES  8'h08
`define SCD_OPC_DATASET_MGMT  8'h09
`define SCD_OPC_RSV_REGISTER  8'h0D
`define SCD_OPC_RSV_REPORT    8'h0E
`define SCD_OPC_RSV_ACQUIRE   8'h11
`define SCD_OPC_RSV_RELEASE   8'h15
// Dword 10 field positions.
`define SCD_SEL_MSB           31
`define SCD_SEL_LSB           24
`define SCD_SPEC_MSB          23
`define SCD_SPEC_LSB          8
`define SCD_TGT_MSB           7
`define SCD_TGT_LSB           0
// Protocol selector and protocol-specific values.
`define SCD_PROTO_DISCOVERY   8'h00
`define SCD_PROTO_STORAGE     8'hEA
`define SCD_SPEC_RPB          16'h0001
// Status codes of a completion entry.
`define SCD_ST_SUCCESS        8'h00
`define SCD_ST_INVALID_OPCODE 8'h01
`define SCD_ST_INVALID_FIELD  8'h02
`define SCD_ST_INVALID_PARAM  8'h0B
// Smallest legal logical block, log2 of 512 bytes.
`define SCD_LB_MIN_SHIFT      4'h9
`define SCD_LB_MAX_SHIFT      4'hF
`endif

/* hdl/scd_pkg.sv */
package scd_pkg;
  // Transfer direction from the two low opcode bits.
  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,
    DIR_H2C  = 2'b01,
    DIR_C2H  = 2'b10,
    DIR_BIDI = 2'b11
  } scd_dir_e;

  // Action the decoder hands to the back end.
  typedef enum logic [3:0] {
    ACT_NONE      = 4'h0,
    ACT_FLUSH     = 4'h1,
    ACT_WRITE     = 4'h2,
    ACT_READ      = 4'h3,
    ACT_MISC      = 4'h4,
    ACT_VENDOR    = 4'h5,
    ACT_DISCOVERY = 4'h6,
    ACT_RPB_SEND  = 4'h7,
    ACT_RPB_RECV  = 4'h8
  } scd_act_e;

  // Submission entry fields the decoder looks at.
  typedef struct packed {
    logic        adminQueue;
    logic [7:0]  opcode;
    logic [15:0] commandId;
    logic        limitedRetryFlag;
    logic [31:0] dword10;
    logic [31:0] dword11;
  } scd_sub_s;

  // Completion entry returned to the host side.
  typedef struct packed {
    logic        adminQueue;
    logic [15:0] commandId;
    logic [7:0]  status;
  } scd_cpl_s;

  // Decoded request handed to the execution side.
  typedef struct packed {
    scd_act_e    action;
    scd_dir_e    direction;
    logic        boundedRecovery;
    logic [7:0]  protocolTargetField;
    logic [31:0] byteCount;
  } scd_req_s;
endpackage

/* hdl/scd_opcode_map.sv */
`timescale 1ns/10ps
`include "scd_regs.svh"
// Combinational lookup of a storage command-set opcode.
module scd_opcode_map (
  input  wire logic [7:0]        opcode,
  input  wire logic              vendorEnable,
  output scd_pkg::scd_act_e      action,
  output logic                   known,
  output logic                   recoveryHint
);
  // Classify the opcode; unknown codes stay reserved.
  always_comb begin
    action       = scd_pkg::ACT_NONE;
    known        = 1'b1;
    recoveryHint = 1'b0;
    unique case (opcode)
      `SCD_OPC_FLUSH:        action = scd_pkg::ACT_FLUSH;
      `SCD_OPC_WRITE: begin
        action       = scd_pkg::ACT_WRITE;
        recoveryHint = 1'b1;
      end
      `SCD_OPC_READ: begin
        action       = scd_pkg::ACT_READ;
        recoveryHint = 1'b1;
      end
      `SCD_OPC_COMPARE, `SCD_OPC_WRITE_ZEROES: begin
        action       = scd_pkg::ACT_MISC;
        recoveryHint = 1'b1;
      end
      `SCD_OPC_WRITE_UNCORR, `SCD_OPC_DATASET_MGMT, `SCD_OPC_RSV_REGISTER,
      `SCD_OPC_RSV_REPORT, `SCD_OPC_RSV_ACQUIRE, `SCD_OPC_RSV_RELEASE: begin
        action = scd_pkg::ACT_MISC;
      end
      default: begin
        // Vendor codes are only honoured when an extension is fitted.
        if (opcode[7] && vendorEnable) begin
          action = scd_pkg::ACT_VENDOR;
        end else begin
          known = 1'b0;
        end
      end
    endcase
  end
endmodule

/* hdl/scd_security_decoder.sv */
`timescale 1ns/10ps
`include "scd_regs.svh"
module scd_security_decoder (
  // Controller clock and its synchronous, active-low reset.
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Host side: one submission entry per cycle, taken only while ready.
  input  wire logic              submitValid,
  input  wire scd_pkg::scd_sub_s submissionEntry,
  // Static configuration, expected to change only between commands.
  input  wire logic              vendorEnable,
  input  wire logic [3:0]        lbSizeShift,
  // Completion side: entry and strobe, both registered.
  output scd_pkg::scd_cpl_s      completionEntry,
  output logic                   completionValid,
  // Execution side: decoded request, raised only for accepted work.
  output scd_pkg::scd_req_s      requestOut,
  output logic                   requestValid,
  // Status levels for the host and the back end.
  output logic                   controllerReadyFlag,
  output logic                   lbSizeError,
  output logic [7:0]             lastSendStatus,
  output logic                   sendStatusValid
);

  ////////////////////////////////////////////////////////////////////////////
  // Field extraction.

  // Selector, specific value and target field out of dword 10.
  logic [7:0]  securityProtocolSelector;
  logic [15:0] protocolSpecificValue;
  logic [7:0]  protocolTargetField;
  logic        isSend;
  logic        isRecv;
  scd_pkg::scd_act_e mapAction;
  logic        mapKnown;
  logic        mapHint;

  // Fields are sliced from the entry as it stands; nothing is registered here.
  // The specific value spans both middle bytes, high byte first.
  assign securityProtocolSelector = submissionEntry.dword10[`SCD_SEL_MSB:`SCD_SEL_LSB];
  assign protocolSpecificValue    = submissionEntry.dword10[`SCD_SPEC_MSB:`SCD_SPEC_LSB];
  assign protocolTargetField      = submissionEntry.dword10[`SCD_TGT_MSB:`SCD_TGT_LSB];
  // Security commands are recognised only on the admin queue.
  assign isSend = submissionEntry.adminQueue && (submissionEntry.opcode == `SCD_OPC_SEC_SEND);
  assign isRecv = submissionEntry.adminQueue && (submissionEntry.opcode == `SCD_OPC_SEC_RECV);

  // Storage opcode table lives in its own small module.
  // Keeping it apart lets the table change without touching the security path.
  scd_opcode_map uMap (
    .opcode       (submissionEntry.opcode),
    .vendorEnable (vendorEnable),
    .action       (mapAction),
    .known        (mapKnown),
    .recoveryHint (mapHint)
  );

  // A block shift is legal only from 512 bytes up; a shift is always a power of two.
  // Fifteen is the largest shift that the four-bit field can express,
  // so only the lower bound needs a test.
  function automatic logic lbShiftBad(input logic [3:0] shift);
    lbShiftBad = (shift < `SCD_LB_MIN_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode of one submission entry.

  scd_pkg::scd_act_e act;
  logic [7:0]        status;
  logic              storageEa;
  logic              securityEa;

  assign storageEa = (securityProtocolSelector == `SCD_PROTO_STORAGE);

  // Target field is only defined for a security command under selector EAh.
  assign securityEa = (isSend || isRecv) && storageEa;

  // Only the queue flag, the opcode and dword 10 are examined for security commands.
  always_comb begin
    act    = scd_pkg::ACT_NONE;
    status = `SCD_ST_SUCCESS;
    // Security commands are handled first; the storage table would take them for vendor codes when vendorEnable is set.
    if (isSend || isRecv) begin
      if (isRecv && securityProtocolSelector == `SCD_PROTO_DISCOVERY) begin
        // Discovery never depends on an earlier send.
        act = scd_pkg::ACT_DISCOVERY;
      end else if (!storageEa) begin
        // Send: reserved selector; receive: unsupported selector.
        status = `SCD_ST_INVALID_PARAM;
      end else if (protocolSpecificValue == `SCD_SPEC_RPB) begin
        // Replay-protected block, in the direction of the command.
        act = isSend ? scd_pkg::ACT_RPB_SEND : scd_pkg::ACT_RPB_RECV;
      end else begin
        // Reserved specific values are refused rather than guessed at.
        status = `SCD_ST_INVALID_FIELD;
      end
    end else if (submissionEntry.adminQueue) begin
      // Any other admin opcode is outside this decoder.
      status = `SCD_ST_INVALID_OPCODE;
    end else if (!mapKnown) begin
      // Reserved or unfitted vendor codes complete at once and move no data.
      status = `SCD_ST_INVALID_OPCODE;
    end else if (lbShiftBad(lbSizeShift) && mapAction != scd_pkg::ACT_FLUSH) begin
      // Flush moves no data, so a bad block size does not stop it.
      status = `SCD_ST_INVALID_FIELD;
    end else begin
      // Everything else goes to the back end as the table says.
      act = mapAction;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready flag.

  // Ready rises one edge after reset is released; submissions before it are dropped.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Held low for as long as reset is asserted.
      controllerReadyFlag <= 1'b0;
    end else begin
      // There is no queue set-up here, so ready simply follows reset.
      controllerReadyFlag <= 1'b1;
    end
  end

  // A submission while ready is low is dropped without any answer.
  logic accept;
  assign accept = submitValid && controllerReadyFlag;

  ////////////////////////////////////////////////////////////////////////////
  // Completion entry.

  // Every accepted entry gets exactly one completion one edge later.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // Nothing is reported while in reset.
      completionValid <= 1'b0;
      completionEntry <= '0;
    end else begin
      completionValid <= accept;
      // Fields hold their value until the next accepted entry.
      if (accept) begin
        // The queue flag tells the host which completion queue the entry belongs to.
        completionEntry.adminQueue <= submissionEntry.adminQueue;
        completionEntry.commandId  <= submissionEntry.commandId;
        completionEntry.status     <= status;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request to the execution side.

  // Rejected entries raise no request, so no data moves for them.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // A cleared request reads as no action.
      requestValid <= 1'b0;
      requestOut   <= '0;
    end else begin
      // Only work that the back end must perform raises the strobe.
      requestValid <= accept && (act != scd_pkg::ACT_NONE);
      if (accept) begin
        requestOut.action    <= act;
        // Direction comes straight from the two low opcode bits.
        requestOut.direction <= scd_pkg::scd_dir_e'(submissionEntry.opcode[1:0]);
        // The hint only matters for compare, read, write and write-zeroes.
        requestOut.boundedRecovery <= mapHint && submissionEntry.limitedRetryFlag;
        // Target is reserved outside selector EAh, so it is passed as zero.
        requestOut.protocolTargetField <= securityEa ? protocolTargetField : 8'h00;
        // Byte count, no 512-byte scaling.
        requestOut.byteCount <= submissionEntry.dword11;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Send result kept for the matching receive.

  // The back end pairs it with a receive; here it is only held.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lastSendStatus  <= `SCD_ST_SUCCESS;
      sendStatusValid <= 1'b0;
    end else if (accept && isSend) begin
      // Failed sends are kept as well, so a receive can report them.
      lastSendStatus  <= status;
      // Cleared only by reset; the first send makes it valid.
      sendStatusValid <= 1'b1;
    end
  end

  // Flags a configured block size below the minimum.
  // Reported as a level so that the host can see it at any time.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      lbSizeError <= 1'b0;
    end else begin
      lbSizeError <= lbShiftBad(lbSizeShift);
    end
  end

endmodule

/* dv/scd_asserts.sv */
`timescale 1ns/10ps
`include "scd_regs.svh"
// Port checker; every answer lands one registered stage after the take.
module scd_asserts (
  input wire logic              mclk,
  input wire logic              rst_n,
  input wire logic              submitValid,
  input wire scd_pkg::scd_sub_s submissionEntry,
  input wire logic              vendorEnable,
  input wire scd_pkg::scd_cpl_s completionEntry,
  input wire logic              completionValid,
  input wire scd_pkg::scd_req_s requestOut,
  input wire logic              requestValid,
  input wire logic              controllerReadyFlag,
  input wire logic [7:0]        lastSendStatus,
  input wire logic              sendStatusValid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Selector of the entry on the port.
  wire logic [7:0]  sel = submissionEntry.dword10[31:24];
  wire logic [15:0] spec = submissionEntry.dword10[23:8];
  // A take needs ready, so requests during reset never count.
  sequence s_acc; submitValid && controllerReadyFlag; endsequence
  sequence s_send; s_acc ##0 submissionEntry.adminQueue && submissionEntry.opcode == `SCD_OPC_SEC_SEND; endsequence
  sequence s_recv; s_acc ##0 submissionEntry.adminQueue && submissionEntry.opcode == `SCD_OPC_SEC_RECV; endsequence
  property p_cpl; s_acc |=> completionValid && completionEntry.commandId == $past(submissionEntry.commandId); endproperty
  a_cpl: assert property (p_cpl) else $error("completion missing");
  property p_disc; s_recv ##0 sel == 8'h00 |=> requestValid && requestOut.action == scd_pkg::ACT_DISCOVERY; endproperty
  a_disc: assert property (p_disc) else $error("discovery not decoded");
  property p_rsv; s_send ##0 sel != 8'hEA && sel != 8'h00 |=> completionEntry.status == `SCD_ST_INVALID_PARAM; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved selector accepted");
  property p_rpb; s_send ##0 sel == 8'hEA && spec == 16'h0001 |=> requestOut.action == scd_pkg::ACT_RPB_SEND
    && requestOut.protocolTargetField == $past(submissionEntry.dword10[7:0]); endproperty
  a_rpb: assert property (p_rpb) else $error("block target wrong");
  property p_spec; s_recv ##0 sel == 8'hEA && spec != 16'h0001 |=> completionEntry.status == `SCD_ST_INVALID_FIELD; endproperty
  a_spec: assert property (p_spec) else $error("reserved specific value accepted");
  property p_vend; s_acc ##0 !submissionEntry.adminQueue && submissionEntry.opcode[7] && !vendorEnable
    |=> completionEntry.status == `SCD_ST_INVALID_OPCODE && !requestValid; endproperty
  a_vend: assert property (p_vend) else $error("vendor opcode not refused");
  property p_dir; s_acc |=> !requestValid || requestOut.direction == $past(submissionEntry.opcode[1:0]); endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_keep; s_send |=> sendStatusValid && lastSendStatus == completionEntry.status; endproperty
  a_keep: assert property (p_keep) else $error("send status not kept");
endmodule
bind scd_security_decoder scd_asserts scd_asserts_i (.*);

/* dv/scd_host_model.sv */
`timescale 1ns/10ps
// Host side: one entry per cycle, called just after a falling edge.
module scd_host_model (
  input  wire logic        mclk,
  input  wire logic        controllerReadyFlag,
  output scd_pkg::scd_sub_s submissionEntry,
  output logic             submitValid
);
  initial begin
    submitValid = 1'b0;
    submissionEntry = '0;
  end
  // A released entry is inverted so stale fields never look valid.
  task automatic drive(input logic v, input scd_pkg::scd_sub_s e);
    while (!controllerReadyFlag) @(negedge mclk);
    submitValid <= v;
    submissionEntry <= v ? e : ~submissionEntry;
  endtask
endmodule

/* dv/tb_top.sv */
`timescale 1ns/10ps
`include "scd_regs.svh"
module tb_top;
  typedef struct packed {logic [7:0] opc; logic [31:0] d10; logic [7:0] st; scd_pkg::scd_act_e act;} scd_row_s;
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              vendorEnable = 1'b0;
  logic [3:0]        lbSizeShift = 4'h9;
  logic              submitValid;
  scd_pkg::scd_sub_s submissionEntry;
  scd_pkg::scd_cpl_s completionEntry;
  scd_pkg::scd_req_s requestOut;
  logic              completionValid, requestValid, controllerReadyFlag, lbSizeError, sendStatusValid;
  logic [7:0]        lastSendStatus;
  scd_pkg::scd_sub_s e = '0;
  int                n_fail = 0;
  int                checks_done = 0;
  // Admin rows, the last a non-security opcode; the first carries a target that must read back as zero.
  scd_row_s rows [8] = '{
    '{8'h82, 32'h0000_0077, 8'h00, scd_pkg::ACT_DISCOVERY}, '{8'h81, 32'hEA00_015A, 8'h00, scd_pkg::ACT_RPB_SEND},
    '{8'h82, 32'hEA00_0133, 8'h00, scd_pkg::ACT_RPB_RECV}, '{8'h81, 32'hEA00_0200, 8'h02, scd_pkg::ACT_NONE},
    '{8'h82, 32'hEAFF_FF00, 8'h02, scd_pkg::ACT_NONE}, '{8'h81, 32'h0500_0000, 8'h0B, scd_pkg::ACT_NONE},
    '{8'h82, 32'h0100_0000, 8'h0B, scd_pkg::ACT_NONE}, '{8'h10, 32'h0000_0000, 8'h01, scd_pkg::ACT_NONE}};
  // Assigned opcodes first, then reserved ones and the unfitted vendor code 80h.
  logic [7:0] ioOps [15] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h05, 8'h08, 8'h09, 8'h0D, 8'h0E, 8'h11, 8'h15,
                             8'h03, 8'h06, 8'h7F, 8'h80};
  scd_pkg::scd_act_e ioAct [3] = '{scd_pkg::ACT_FLUSH, scd_pkg::ACT_WRITE, scd_pkg::ACT_READ};
  always #10 mclk = ~mclk;
  scd_security_decoder scd_security_decoder_i (.*);
  scd_host_model scd_host_model_i (.*);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Back to back: the next entry goes out at the edge the answer is read.
  task automatic xfer(input logic adm, input logic [7:0] opc, input logic [31:0] d10, input logic lr,
                      input logic [7:0] st, input scd_pkg::scd_act_e act);
    e.adminQueue = adm;
    e.opcode = opc;
    e.commandId = e.commandId + 16'h0001;
    e.limitedRetryFlag = lr;
    e.dword10 = d10;
    e.dword11 = {d10[15:0], opc, 8'h5A};
    scd_host_model_i.drive(1'b1, e);
    @(negedge mclk);
    chk(completionValid, 1'b1);
    chk({completionEntry.adminQueue, completionEntry.commandId}, {adm, e.commandId});
    chk(completionEntry.status, st);
    chk(requestValid, act != scd_pkg::ACT_NONE);
    if (act != scd_pkg::ACT_NONE) begin
      chk(requestOut.action, act);
      chk(requestOut.direction, opc[1:0]);
      chk(requestOut.byteCount, e.dword11);
      chk(requestOut.protocolTargetField, (adm && d10[31:24] == 8'hEA) ? d10[7:0] : 8'h00);
    end
  endtask
  task automatic end_sim;
    $display("checks=%0d fails=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge mclk);
    chk({controllerReadyFlag, completionValid}, 2'b00);
    rst_n = 1'b1;
    @(negedge mclk);
    chk(controllerReadyFlag, 1'b1);
    foreach (rows[i]) xfer(1'b1, rows[i].opc, rows[i].d10, 1'b0, rows[i].st, rows[i].act);
    // Limited retry is set on every storage row; only four commands may pass it on.
    foreach (ioOps[i]) begin
      xfer(1'b0, ioOps[i], 32'h0000_0000, 1'b1, i < 11 ? 8'h00 : 8'h01,
           i < 3 ? ioAct[i] : (i < 11 ? scd_pkg::ACT_MISC : scd_pkg::ACT_NONE));
      if (i < 11) chk(requestOut.boundedRecovery, ioOps[i] inside {8'h01, 8'h02, 8'h05, 8'h08});
    end
    vendorEnable = 1'b1;
    xfer(1'b0, 8'hC1, 32'h0000_0000, 1'b0, 8'h00, scd_pkg::ACT_VENDOR);
    vendorEnable = 1'b0;
    xfer(1'b0, 8'h02, 32'h0000_0000, 1'b1, 8'h00, scd_pkg::ACT_READ);
    chk(requestOut.boundedRecovery, 1'b1);
    xfer(1'b0, 8'h00, 32'h0000_0000, 1'b1, 8'h00, scd_pkg::ACT_FLUSH);
    chk(requestOut.boundedRecovery, 1'b0);
    xfer(1'b1, 8'h81, 32'h0500_0000, 1'b0, 8'h0B, scd_pkg::ACT_NONE);
    xfer(1'b1, 8'h82, 32'h0000_0000, 1'b0, 8'h00, scd_pkg::ACT_DISCOVERY);
    chk({sendStatusValid, lastSendStatus}, 9'h10B);
    lbSizeShift = 4'h8;
    xfer(1'b0, 8'h02, 32'h0000_0000, 1'b0, 8'h02, scd_pkg::ACT_NONE);
    xfer(1'b0, 8'h00, 32'h0000_0000, 1'b0, 8'h00, scd_pkg::ACT_FLUSH);
    chk(lbSizeError, 1'b1);
    lbSizeShift = 4'h9;
    scd_host_model_i.drive(1'b0, e);
    repeat (2) @(negedge mclk);
    chk({completionValid, requestValid, lbSizeError}, 3'b000);
    // Reset in mid-run with an entry standing: nothing is taken until ready is back.
    scd_host_model_i.drive(1'b1, e);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    chk({controllerReadyFlag, completionValid, requestValid, sendStatusValid, lastSendStatus}, 12'h000);
    rst_n = 1'b1;
    @(negedge mclk);
    chk({controllerReadyFlag, completionValid}, 2'b10);
    xfer(1'b1, 8'h82, 32'h0000_0000, 1'b0, 8'h00, scd_pkg::ACT_DISCOVERY);
    chk(sendStatusValid, 1'b0);
    end_sim();
  end
  // Whole run is well under a hundred cycles.
  initial begin
    repeat (1000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
endmodule
